// File: shared/tmr_pkg.sv
// Constants, codes and state layouts shared by the timer-2 design files.
`default_nettype none
package tmr_pkg;
  // Register offsets in the IO address space.
  localparam logic [5:0] T2_LIMIT_VALUE_OFS   = 6'h09;
  localparam logic [5:0] T2_CONTROL_OFS       = 6'h1c;
  localparam logic [5:0] T2_COUNT_VALUE_OFS   = 6'h1d;
  localparam logic [5:0] T2_DIVIDER_SETUP_OFS = 6'h1e;

  // Field positions in the control and divider setup registers.
  localparam int CTRL_SRC_LSB   = 4;
  localparam int CTRL_ROUTE_LSB = 2;
  localparam int CTRL_MODE_BIT  = 1;
  localparam int CTRL_INV_BIT   = 0;
  localparam int DIV_RES_BIT    = 7;
  localparam int DIV_PRE_LSB    = 5;

  // Values after reset.
  localparam logic [7:0] REG_RESET = 8'h00;

  // Wrap points of the two PWM resolutions.
  localparam logic [7:0] WRAP_8BIT = 8'hff;
  localparam logic [7:0] WRAP_6BIT = 8'h3f;

  // Prescaler terminal counts for divide by 1, 4, 16 and 64.
  localparam logic [5:0] PRE_LAST_1  = 6'h00;
  localparam logic [5:0] PRE_LAST_4  = 6'h03;
  localparam logic [5:0] PRE_LAST_16 = 6'h0f;
  localparam logic [5:0] PRE_LAST_64 = 6'h3f;

  // Count clock sources; every other code is reserved and yields no ticks.
  typedef enum logic [3:0] {
    SRC_STOP = 4'b0000,
    SRC_SYS  = 4'b0001,
    SRC_FAST = 4'b0010,
    SRC_SLOW = 4'b0100,
    SRC_CMP  = 4'b0101,
    SRC_RISE = 4'b1000,
    SRC_FALL = 4'b1001
  } tmr_src_t;

  // Output routing codes.
  localparam logic [1:0] ROUTE_NONE    = 2'b00;
  localparam logic [1:0] ROUTE_B_TWO   = 2'b01;
  localparam logic [1:0] ROUTE_A_THREE = 2'b10;
  localparam logic [1:0] ROUTE_B_FOUR  = 2'b11;

  // State of the tick generator.
  typedef struct packed {
    logic       src_q;
    logic [5:0] pre_cnt;
    logic [4:0] scl_cnt;
    logic       tick;
  } tmr_tick_state_t;

  // State of the timer core.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] count;
    logic [7:0] div;
    logic [7:0] limit;
    logic       wave;
    logic [7:0] rdata;
    logic [2:0] pin;
    logic [2:0] drive_n;
  } tmr_core_state_t;
endpackage : tmr_pkg
`default_nettype wire

// File: shared/tmr_tick_if.sv
// Count clock configuration and scaled tick between the timer core and its tick generator.
`default_nettype none
interface tmr_tick_if;
  logic [3:0] src;
  logic [1:0] pre;
  logic [4:0] scl;
  logic       tick;

  modport gen (input src, input pre, input scl, output tick);
  modport user (output src, output pre, output scl, input tick);
endinterface : tmr_tick_if
`default_nettype wire

// File: hdl/tmr_tick_gen.sv
// Count clock source selection, prescaler and clock scaler of timer 2.
`default_nettype none
module tmr_tick_gen
  import tmr_pkg::*;
(
  // Clock and reset.
  input  wire logic sys_clk,
  input  wire logic rst_n,
  // Candidate count clock sources, sampled on sys_clk.
  input  wire logic fast_internal_oscillator,
  input  wire logic slow_internal_oscillator,
  input  wire logic cmp_out,
  input  wire logic port_a_pin_zero,
  // Configuration in, scaled tick out.
  tmr_tick_if.gen   tk
);
  tmr_tick_state_t q;
  tmr_tick_state_t next_q;
  logic            lvl;
  logic            edge_hit;
  logic [5:0]      pre_last;

  // Source edge detection; oscillators faster than half of sys_clk will alias.
  always_comb
  begin
    next_q = q;
    next_q.tick = 1'b0;
    unique case (tk.pre)
      2'b00: pre_last = PRE_LAST_1;
      2'b01: pre_last = PRE_LAST_4;
      2'b10: pre_last = PRE_LAST_16;
      2'b11: pre_last = PRE_LAST_64;
    endcase
    lvl = 1'b0;
    edge_hit = 1'b0;
    case (tk.src)
      SRC_SYS:  edge_hit = 1'b1;
      SRC_FAST: lvl = fast_internal_oscillator;
      SRC_SLOW: lvl = slow_internal_oscillator;
      SRC_CMP:  lvl = cmp_out;
      SRC_RISE, SRC_FALL: lvl = port_a_pin_zero;
      default:  lvl = 1'b0;
    endcase
    if (tk.src == SRC_FALL)
      edge_hit = q.src_q && !lvl;
    else if (tk.src != SRC_SYS && tk.src != SRC_STOP)
      edge_hit = !q.src_q && lvl;
    next_q.src_q = lvl;
    // The scaler divides by its field plus one, after the prescaler.
    if (edge_hit)
    begin
      if (q.pre_cnt >= pre_last)
      begin
        next_q.pre_cnt = 6'h00;
        if (q.scl_cnt >= tk.scl)
        begin
          next_q.scl_cnt = 5'h00;
          next_q.tick = 1'b1;
        end
        else
          next_q.scl_cnt = q.scl_cnt + 5'h01;
      end
      else
        next_q.pre_cnt = q.pre_cnt + 6'h01;
    end
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign tk.tick = q.tick;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_stopped;
    tk.src == SRC_STOP;
  endsequence

  sequence s_sys_undivided;
    tk.src == SRC_SYS && tk.pre == 2'b00 && tk.scl == 5'h00;
  endsequence

  a_stop_no_tick: assert property (s_stopped ##1 s_stopped |-> !tk.tick)
    else $error("Tick seen while the timer clock is stopped.");
  a_sys_every_cycle: assert property (s_sys_undivided |=> tk.tick)
    else $error("System clock source did not tick every cycle.");
  a_fall_edge_tick: assert property ((tk.src == SRC_FALL && tk.pre == 2'b00 && tk.scl == 5'h00
    && q.src_q && !port_a_pin_zero) |=> tk.tick)
    else $error("Falling pin edge did not produce a tick.");
  a_pre_by_four: assert property ((tk.src == SRC_SYS && tk.pre == 2'b01 && tk.scl == 5'h00
    && tk.tick)[*1] ##1 (tk.src == SRC_SYS && tk.pre == 2'b01 && tk.scl == 5'h00)[*3]
    |-> !tk.tick)
    else $error("Divide by four produced ticks too close together.");
endmodule : tmr_tick_gen
`default_nettype wire

// File: hdl/tmr_timer2.sv
// Timer 2 core: IO registers, period and PWM counting, output polarity and pin routing.
`default_nettype none
// How it works
// - Source field selects count clock or stops it
// - Codes 1000/1001 count pin rising/falling edges
// - Routing field picks no pin or one of three
// - Control bit 1 selects period or PWM
// - Control bit 0 inverts the output polarity
// - Counter register readable, writable, resets zero
// - Divider bit 7 selects 8 or 6-bit PWM
// - Prescale field divides by 1, 4, 16, 64
// - Five-bit scaler further divides prescaled clock
// - Write-only limit register is comparison value, resets zero
module tmr_timer2
  import tmr_pkg::*;
(
  // Clock and reset.
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // IO register access.
  input  wire logic [5:0] io_addr,
  input  wire logic       io_wr,
  input  wire logic       io_rd,
  input  wire logic [7:0] io_wdata,
  output logic      [7:0] io_rdata,
  // Count clock sources.
  input  wire logic       fast_internal_oscillator,
  input  wire logic       slow_internal_oscillator,
  input  wire logic       cmp_out,
  input  wire logic       port_a_pin_zero,
  // Timer output pins, drive enables active low.
  output logic            port_b_pin_two,
  output logic            port_b_pin_two_drive_n,
  output logic            port_a_pin_three,
  output logic            port_a_pin_three_drive_n,
  output logic            port_b_pin_four,
  output logic            port_b_pin_four_drive_n
);
  tmr_core_state_t q;
  tmr_core_state_t next_q;
  logic            count_wr;
  logic [7:0]      wrap;
  logic            out_lvl;

  tmr_tick_if tk ();

  // Tick generator sees the configuration fields directly.
  assign tk.src = q.ctrl[CTRL_SRC_LSB +: 4];
  assign tk.pre = q.div[DIV_PRE_LSB +: 2];
  assign tk.scl = q.div[4:0];

  tmr_tick_gen u_tick (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .fast_internal_oscillator (fast_internal_oscillator),
    .slow_internal_oscillator (slow_internal_oscillator),
    .cmp_out                  (cmp_out),
    .port_a_pin_zero          (port_a_pin_zero),
    .tk                       (tk)
  );

  // Register writes, counting and output shaping. A software write to the
  // counter wins over a tick in the same cycle so software sees its value stick.
  always_comb
  begin
    next_q = q;
    count_wr = io_wr && io_addr == T2_COUNT_VALUE_OFS;
    wrap = q.div[DIV_RES_BIT] ? WRAP_6BIT : WRAP_8BIT;
    if (io_wr && io_addr == T2_CONTROL_OFS)
      next_q.ctrl = io_wdata;
    if (io_wr && io_addr == T2_DIVIDER_SETUP_OFS)
      next_q.div = io_wdata;
    if (io_wr && io_addr == T2_LIMIT_VALUE_OFS)
      next_q.limit = io_wdata;
    if (count_wr)
      next_q.count = io_wdata;
    else if (tk.tick)
    begin
      if (!q.ctrl[CTRL_MODE_BIT])
      begin
        if (q.count == q.limit)
        begin
          next_q.count = REG_RESET;
          next_q.wave = !q.wave;
        end
        else
          next_q.count = q.count + 8'h01;
      end
      else if (q.count >= wrap)
        next_q.count = REG_RESET;
      else
        next_q.count = q.count + 8'h01;
    end
    // PWM level follows the counter directly; period mode keeps its toggle.
    if (q.ctrl[CTRL_MODE_BIT])
      next_q.wave = next_q.count < q.limit;
    // Reads return one cycle later; write-only and unmapped addresses read zero.
    next_q.rdata = q.rdata;
    if (io_rd)
    begin
      unique case (io_addr)
        T2_CONTROL_OFS:     next_q.rdata = q.ctrl;
        T2_COUNT_VALUE_OFS: next_q.rdata = q.count;
        default:            next_q.rdata = REG_RESET;
      endcase
    end
    // Pins lag the wave by one cycle so every output comes from a flip-flop.
    out_lvl = q.wave ^ q.ctrl[CTRL_INV_BIT];
    next_q.pin = {3{out_lvl}};
    next_q.drive_n = 3'b111;
    unique case (q.ctrl[CTRL_ROUTE_LSB +: 2])
      ROUTE_NONE:    next_q.drive_n = 3'b111;
      ROUTE_B_TWO:   next_q.drive_n = 3'b110;
      ROUTE_A_THREE: next_q.drive_n = 3'b101;
      ROUTE_B_FOUR:  next_q.drive_n = 3'b011;
    endcase
  end

  // State register.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.drive_n <= 3'b111;
    end
    else
      q <= next_q;
  end

  assign io_rdata = q.rdata;
  assign port_b_pin_two = q.pin[0];
  assign port_a_pin_three = q.pin[1];
  assign port_b_pin_four = q.pin[2];
  assign port_b_pin_two_drive_n = q.drive_n[0];
  assign port_a_pin_three_drive_n = q.drive_n[1];
  assign port_b_pin_four_drive_n = q.drive_n[2];

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_tick_no_write;
    tk.tick && !(io_wr && io_addr == T2_COUNT_VALUE_OFS);
  endsequence

  a_period_match: assert property (s_tick_no_write and (!q.ctrl[1] && q.count == q.limit)
    |=> q.count == 8'h00 && q.wave != $past(q.wave))
    else $error("Period match did not restart and toggle.");
  a_pwm_level: assert property (q.ctrl[1] && $past(q.ctrl[1]) && $stable(q.limit)
    |-> q.wave == (q.count < q.limit))
    else $error("PWM level does not follow count below limit.");
  a_six_wrap: assert property (s_tick_no_write and (q.ctrl[1] && q.div[7] && q.count == 8'h3f)
    |=> q.count == 8'h00)
    else $error("Six-bit PWM did not wrap at 64.");
  a_eight_pass: assert property (s_tick_no_write and (q.ctrl[1] && !q.div[7] && q.count == 8'h3f)
    |=> q.count == 8'h40)
    else $error("Eight-bit PWM wrapped early.");
  a_route_b_two: assert property (q.ctrl[3:2] == 2'b01 |=> !port_b_pin_two_drive_n
    && port_b_pin_two == ($past(q.wave) ^ $past(q.ctrl[0])) && port_a_pin_three_drive_n)
    else $error("Output not routed to port B pin two.");
  a_invert_out: assert property (q.ctrl[3:2] == 2'b11 && q.ctrl[0] |=> port_b_pin_four != $past(q.wave))
    else $error("Inverted polarity not applied.");
  a_limit_write: assert property (io_wr && io_addr == T2_LIMIT_VALUE_OFS |=> q.limit == $past(io_wdata))
    else $error("Limit value not stored.");
  a_count_read: assert property (io_rd && io_addr == T2_COUNT_VALUE_OFS |=> io_rdata == $past(q.count))
    else $error("Counter read back wrong value.");
  // The default disable would hide this check, since its antecedent is reset itself.
  a_reset_zero: assert property (@(posedge sys_clk) disable iff (1'b0) !rst_n |=> q.count == 8'h00
    && q.limit == 8'h00 && q.div == 8'h00)
    else $error("Registers not zero after reset.");

  // Register accesses and counter ticks that the checks below are built from.
  sequence s_count_write;
    io_wr && io_addr == T2_COUNT_VALUE_OFS;
  endsequence

  sequence s_wo_read;
    io_rd && (io_addr == T2_LIMIT_VALUE_OFS || io_addr == T2_DIVIDER_SETUP_OFS);
  endsequence

  sequence s_period_tick;
    tk.tick && !count_wr && !q.ctrl[CTRL_MODE_BIT];
  endsequence

  sequence s_pwm_tick;
    tk.tick && !count_wr && q.ctrl[CTRL_MODE_BIT];
  endsequence

  // Every register write lands on the following edge.
  a_count_write: assert property (s_count_write |=> q.count == $past(io_wdata))
    else $error("Counter write not stored.");
  a_ctrl_write: assert property (io_wr && io_addr == T2_CONTROL_OFS |=> q.ctrl == $past(io_wdata))
    else $error("Control write not stored.");
  a_div_write: assert property (io_wr && io_addr == T2_DIVIDER_SETUP_OFS |=> q.div == $past(io_wdata))
    else $error("Divider setup write not stored.");

  // Write-only registers read as zero; read data stands until the next read.
  a_read_refused: assert property (s_wo_read |=> io_rdata == 8'h00)
    else $error("Write-only register returned data.");
  a_rdata_hold: assert property (!io_rd |=> $stable(io_rdata))
    else $error("Read data changed without a read.");

  // Without a tick the counter rests; a period tick off the limit steps it by one.
  a_idle_hold: assert property (!tk.tick && !count_wr |=> $stable(q.count))
    else $error("Counter moved without a tick.");
  a_period_step: assert property (s_period_tick and (q.count != q.limit)
    |=> q.count == 8'($past(q.count) + 8'h01))
    else $error("Period count did not advance by one.");
  a_period_wave: assert property (!q.ctrl[1] && !(tk.tick && q.count == q.limit)
    |=> $stable(q.wave))
    else $error("Period output changed away from a match.");
  a_pwm_eight_wrap: assert property (s_pwm_tick and (!q.div[7] && q.count == 8'hff)
    |=> q.count == 8'h00)
    else $error("Eight-bit PWM did not wrap at 256.");

  // Only the selected pin is driven; the others keep their enables high.
  a_route_none: assert property (q.ctrl[CTRL_ROUTE_LSB +: 2] == ROUTE_NONE
    |=> port_b_pin_two_drive_n && port_a_pin_three_drive_n && port_b_pin_four_drive_n)
    else $error("A pin is driven with routing off.");
  a_route_a_three: assert property (q.ctrl[CTRL_ROUTE_LSB +: 2] == ROUTE_A_THREE
    |=> !port_a_pin_three_drive_n && port_b_pin_two_drive_n && port_b_pin_four_drive_n)
    else $error("Output not routed to port A pin three.");
  a_route_b_four: assert property (q.ctrl[CTRL_ROUTE_LSB +: 2] == ROUTE_B_FOUR
    |=> !port_b_pin_four_drive_n && port_b_pin_two_drive_n && port_a_pin_three_drive_n)
    else $error("Output not routed to port B pin four.");
endmodule : tmr_timer2
`default_nettype wire

// File: verification/tmr_timer2_tb.sv
// Self-checking bench for the timer-2 core, driven through its IO register port.
`default_nettype none
module tb
  import tmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic       sys_clk     = 1'b0;
  logic       rst_n       = 1'b0;
  logic [5:0] io_addr     = 6'h00;
  logic       io_wr       = 1'b0;
  logic       io_rd       = 1'b0;
  logic [7:0] io_wdata    = 8'h00;
  logic [7:0] io_rdata;
  logic [3:0] src_in      = 4'h0;
  logic [2:0] pin_lvl;
  logic [2:0] pin_drv_n;
  logic [15:0] n;
  logic       l;
  int         mismatches  = 0;
  int         checks_done = 0;
  int         cycles      = 0;

  // Divider setups with the limit and the expected half-wave length in clock cycles.
  logic [7:0]  div_tab [6] = '{8'h00, 8'h20, 8'h40, 8'h60, 8'h02, 8'h21};
  logic [7:0]  lim_tab [6] = '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [15:0] gap_tab [6] = '{16'h0004, 16'h0004, 16'h0010, 16'h0040, 16'h0003, 16'h0010};
  // Source codes and the inputs toggled for each; a full mask marks a code that must not count.
  logic [3:0]  code_tab [9] = '{4'h2, 4'h4, 4'h5, 4'h8, 4'h9, 4'h3, 4'h6, 4'h7, 4'h0};
  logic [3:0]  mask_tab [9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h8, 4'hf, 4'hf, 4'hf, 4'hf};

  tmr_timer2 dut_u (
    .sys_clk                  (sys_clk),
    .rst_n                    (rst_n),
    .io_addr                  (io_addr),
    .io_wr                    (io_wr),
    .io_rd                    (io_rd),
    .io_wdata                 (io_wdata),
    .io_rdata                 (io_rdata),
    .fast_internal_oscillator (src_in[0]),
    .slow_internal_oscillator (src_in[1]),
    .cmp_out                  (src_in[2]),
    .port_a_pin_zero          (src_in[3]),
    .port_b_pin_two           (pin_lvl[0]),
    .port_b_pin_two_drive_n   (pin_drv_n[0]),
    .port_a_pin_three         (pin_lvl[1]),
    .port_a_pin_three_drive_n (pin_drv_n[1]),
    .port_b_pin_four          (pin_lvl[2]),
    .port_b_pin_four_drive_n  (pin_drv_n[2])
  );

  // Free-running 100 MHz clock.
  always #5 sys_clk = ~sys_clk;

  // Prints the verdict and ends the run.
  task automatic stop_test;
    if (mismatches == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : stop_test

  // A hang must still reach the verdict, so a cycle ceiling cuts the run short.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // Compares one observed value with its expectation.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write strobe; a write takes effect at the next edge.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    io_addr  <= a;
    io_wdata <= d;
    io_wr    <= 1'b1;
    @(posedge sys_clk);
    io_wr    <= 1'b0;
  endtask : wr

  // One-cycle read strobe; data is taken once the answering edge has settled.
  task automatic rdchk(input logic [5:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    io_addr <= a;
    io_rd   <= 1'b1;
    @(posedge sys_clk);
    io_rd   <= 1'b0;
    @(negedge sys_clk);
    check({8'h00, io_rdata}, {8'h00, exp});
  endtask : rdchk

  // Cycles until port B pin two changes, and the level it held meanwhile.
  task automatic gap(output logic [15:0] len, output logic lvl);
    len = 16'h0000;
    lvl = pin_lvl[0];
    while (len < 16'h0800 && pin_lvl[0] === lvl)
    begin
      @(negedge sys_clk);
      len++;
    end
  endtask : gap

  // Main sequence.
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(T2_COUNT_VALUE_OFS, 8'h00);
    rdchk(T2_CONTROL_OFS, 8'h00);
    rdchk(T2_LIMIT_VALUE_OFS, 8'h00);
    rdchk(T2_DIVIDER_SETUP_OFS, 8'h00);
    // Timer stopped with inversion on, so each routed pin shows a high level.
    for (int r = 0; r < 4; r++)
    begin
      wr(T2_CONTROL_OFS, {4'h0, 2'(r), 2'b01});
      repeat (3) @(negedge sys_clk);
      check({13'h0, pin_drv_n}, (r == 0) ? 16'h0007 : {13'h0, ~(3'b001 << (r - 1))});
      if (r != 0)
        check({15'h0, pin_lvl[r - 1]}, 16'h0001);
      rdchk(T2_CONTROL_OFS, {4'h0, 2'(r), 2'b01});
    end
    wr(T2_CONTROL_OFS, 8'h04);
    repeat (3) @(negedge sys_clk);
    check({15'h0, pin_lvl[0]}, 16'h0000);
    // Count register access; an unmapped write must leave it alone.
    wr(T2_COUNT_VALUE_OFS, 8'ha5);
    wr(6'h3f, 8'h5a);
    rdchk(T2_COUNT_VALUE_OFS, 8'ha5);
    rdchk(6'h3f, 8'h00);
    // Reset limit and divider: the output toggles on every system clock tick.
    wr(T2_CONTROL_OFS, 8'h14);
    gap(n, l);
    gap(n, l);
    check(n, 16'h0001);
    // Prescaler and scaler settings in period mode; early gaps flush the change.
    for (int i = 0; i < 6; i++)
    begin
      wr(T2_DIVIDER_SETUP_OFS, div_tab[i]);
      wr(T2_LIMIT_VALUE_OFS, lim_tab[i]);
      repeat (3) gap(n, l);
      check(n, gap_tab[i]);
    end
    // PWM at 8-bit and 6-bit resolution: high for limit ticks of each wrap.
    wr(T2_CONTROL_OFS, 8'h16);
    for (int j = 0; j < 2; j++)
    begin
      wr(T2_DIVIDER_SETUP_OFS, (j == 1) ? 8'h80 : 8'h00);
      wr(T2_LIMIT_VALUE_OFS, (j == 1) ? 8'h20 : 8'h40);
      repeat (3) gap(n, l);
      repeat (2)
      begin
        gap(n, l);
        check(n, l ? ((j == 1) ? 16'h0020 : 16'h0040) : ((j == 1) ? 16'h0020 : 16'h00c0));
      end
    end
    // Each count source but the system clock counts its own pulses; stop and reserved codes 3, 6 and 7 count nothing.
    wr(T2_LIMIT_VALUE_OFS, 8'hff);
    wr(T2_DIVIDER_SETUP_OFS, 8'h00);
    for (int c = 0; c < 9; c++)
    begin
      wr(T2_CONTROL_OFS, {code_tab[c], 4'h0});
      repeat (4) @(posedge sys_clk);
      wr(T2_COUNT_VALUE_OFS, 8'h00);
      repeat (3)
      begin
        src_in <= mask_tab[c];
        repeat (4) @(posedge sys_clk);
        src_in <= 4'h0;
        repeat (4) @(posedge sys_clk);
      end
      rdchk(T2_COUNT_VALUE_OFS, (mask_tab[c] == 4'hf) ? 8'h00 : 8'h03);
    end
    // A reset in mid-run clears what software left set, pin routing included.
    wr(T2_CONTROL_OFS, 8'h0d);
    wr(T2_COUNT_VALUE_OFS, 8'h5a);
    rst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(T2_COUNT_VALUE_OFS, 8'h00);
    rdchk(T2_CONTROL_OFS, 8'h00);
    check({13'h0, pin_drv_n}, 16'h0007);
    stop_test();
  end
endmodule : tb
`default_nettype wire
